//--- rtl/prf_gp_bank.v
/*
 * general-purpose storage: flip-flops, one byte per entry, two read and
 * two write ports so a 16-bit pair moves in one cycle.
 * assumes the caller only writes populated entries; no reset on the array.
 */
module prf_gp_bank #(
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire clk,             // core clock
  input wire weEven,          // write the even entry
  input wire weOdd,           // write the odd entry
  input wire [AW-1:0] addrEven, // even entry index
  input wire [AW-1:0] addrOdd,  // odd entry index
  input wire [7:0] wdataEven, // data for even entry
  input wire [7:0] wdataOdd,  // data for odd entry
  output wire [7:0] rdataEven, // read of even entry
  output wire [7:0] rdataOdd   // read of odd entry
);

  reg [7:0] mem [0:DEPTH-1];

  ////////////////////////////////////////////////////////////////////////
  // contents survive reset and start undefined
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      localparam integer IDX = i;
      always @(posedge clk) begin
        if (weEven && addrEven == IDX[AW-1:0]) begin
          mem[i] <= wdataEven;
        end else if (weOdd && addrOdd == IDX[AW-1:0]) begin
          mem[i] <= wdataOdd;
        end
      end
    end
  endgenerate

  assign rdataEven = mem[addrEven];
  assign rdataOdd = mem[addrOdd];

endmodule

//--- rtl/prf_register_file.v
/*
 * paged register file of an 8-bit core: page 0 control registers,
 * virtual working window, peripheral ranges passed out, and populated
 * general-purpose pages in flip-flops. reads return one cycle after the
 * request, from flip-flops.
 * assumes the execution logic on the same clock drives the request
 * ports, and peripheral logic answers periphRdata combinationally for
 * the periphAddr it is shown, which trails the request by one cycle.
 */
`include "prf_regs.vh"

module prf_register_file #(
  parameter PAGES = 2,            // populated pages, 1..16
  parameter HAS_SPH = 1,          // stack pointer high built
  parameter HAS_IRQ2 = 1,         // second mask/request pair built
  parameter HAS_ABS = 1           // 12-bit addressing built
) (
  input wire clk,                 // core clock
  input wire rst_n,               // asynchronous reset, active low
  input wire reqValid,            // access request this cycle
  input wire reqWrite,            // 1 write, 0 read
  input wire reqWord,             // 16-bit pair access
  input wire reqSource,           // operand is a source: never written
  input wire reqIndirect,         // address came from a register
  input wire [1:0] reqMode,       // in-page, working or absolute
  input wire [11:0] reqAddr,      // address, width used per mode
  input wire [15:0] reqWdata,     // write data, byte in low bits
  input wire setPointer,          // set-pointer instruction load
  input wire [7:0] setPointerData, // value for the pointer
  input wire hwFlagsWe,           // hardware update of flags
  input wire [7:0] hwFlags,       // hardware flags value
  input wire hwIrqSet1,           // hardware raises request bits
  input wire [7:0] hwIrqBits1,    // request bits 1 to set
  input wire hwIrqSet2,           // hardware raises request bits 2
  input wire [7:0] hwIrqBits2,    // request bits 2 to set
  input wire hwSpWe,              // hardware stack pointer update
  input wire [15:0] hwSp,         // new stack pointer
  input wire [7:0] writeLockMask, // bits of periph register locked
  input wire [7:0] periphRdata,   // peripheral read data
  output reg [15:0] rdData,       // read data, byte in low bits
  output reg rdValid,             // read data valid pulse
  output reg accessError,         // pulse: undefined access; a reserved access reads zero without error
  output reg periphWe,            // peripheral write strobe
  output reg periphRe,            // peripheral read strobe
  output reg [7:0] periphAddr,    // in-page peripheral address
  output reg [7:0] periphWdata,   // peripheral write data
  output reg [7:0] registerPointer, // pointer, for the core
  output reg [7:0] conditionFlags,  // flags, for the core
  output reg [15:0] stackPointer,   // high and low bytes
  output reg [7:0] interruptMask1,  // mask 1
  output reg [7:0] interruptRequest1, // request 1
  output reg [7:0] interruptMask2,  // mask 2
  output reg [7:0] interruptRequest2  // request 2
);

  // storage depth and index width follow the populated pages
  localparam DEPTH = PAGES * 256;
  localparam AW = (PAGES > 8) ? 12 : (PAGES > 4) ? 11 :
                  (PAGES > 2) ? 10 : (PAGES > 1) ? 9 : 8;

  ////////////////////////////////////////////////////////////////////////
  // address formation for both bytes of the access
  reg [11:0] absEven;
  reg [11:0] absOdd;
  reg [7:0] inPage;
  reg [3:0] page;
  reg undefinedAccess;

  always @* begin
    page = registerPointer[3:0];
    inPage = reqAddr[7:0];
    undefinedAccess = 1'b0;
    case (reqMode)
      `PRF_MODE_WORKING: begin
        inPage = {registerPointer[7:4], reqAddr[3:0]};
      end
      `PRF_MODE_ABSOLUTE: begin
        page = reqAddr[11:8];
        undefinedAccess = (HAS_ABS == 0);
      end
      default: begin
        inPage = reqAddr[7:0];
      end
    endcase
    // window redirect happens once, direct addressing only
    if (page == 4'h0 && inPage[7:4] == `PRF_NIB_VIRT) begin
      if (reqIndirect) begin
        undefinedAccess = 1'b1;
      end else begin
        inPage = {registerPointer[7:4], inPage[3:0]};
      end
    end
    // pointer aimed at group E of page 0 is left undefined: the window
    // would point back at itself, so the access is refused instead
    if (page == 4'h0 && inPage[7:4] == `PRF_NIB_VIRT) begin
      undefinedAccess = 1'b1;
    end
    absEven = {page, inPage[7:1], inPage[0] & ~reqWord};
    absOdd = {page, inPage[7:1], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////
  // region decode
  function [2:0] region;
    input [11:0] a;
    begin
      // 0 storage, 1 control, 2 periph, 3 reserved/absent
      if (a[11:8] >= PAGES) begin
        region = 3'h3;
      end else if (a[11:8] != 4'h0) begin
        region = 3'h0;
      end else if (a[7] == 1'b0) begin
        region = 3'h0;
      end else if (a[7:4] == `PRF_NIB_CTRL) begin
        region = 3'h1;
      end else if (a[7:4] == `PRF_NIB_PORT || a[7:4] == `PRF_NIB_TIMER) begin
        region = 3'h2;
      end else begin
        region = 3'h3;
      end
    end
  endfunction

  function ctrlPresent;
    input [7:0] a;
    begin
      case (a)
        `PRF_OFF_SPL, `PRF_OFF_REGISTER_POINTER, `PRF_OFF_FLAGS,
        `PRF_OFF_IMASK1, `PRF_OFF_IREQ1: ctrlPresent = 1'b1;
        `PRF_OFF_SPH: ctrlPresent = (HAS_SPH != 0);
        `PRF_OFF_INTERRUPT_MASK_2, `PRF_OFF_INTERRUPT_REQUEST_2: ctrlPresent = (HAS_IRQ2 != 0);
        default: ctrlPresent = 1'b0;
      endcase
    end
  endfunction

  function [7:0] ctrlRead;
    input [7:0] a;
    begin
      case (a)
        `PRF_OFF_SPL: ctrlRead = stackPointer[7:0];
        `PRF_OFF_SPH: ctrlRead = stackPointer[15:8];
        `PRF_OFF_REGISTER_POINTER: ctrlRead = registerPointer;
        `PRF_OFF_FLAGS: ctrlRead = conditionFlags;
        `PRF_OFF_IMASK1: ctrlRead = interruptMask1;
        `PRF_OFF_IREQ1: ctrlRead = interruptRequest1;
        `PRF_OFF_INTERRUPT_MASK_2: ctrlRead = interruptMask2;
        `PRF_OFF_INTERRUPT_REQUEST_2: ctrlRead = interruptRequest2;
        default: ctrlRead = 8'h00;
      endcase
    end
  endfunction

  wire [2:0] regEven = region(absEven);
  wire [2:0] regOdd = region(absOdd);
  wire presEven = (regEven == 3'h0) || (regEven == 3'h2) ||
                  (regEven == 3'h1 && ctrlPresent(absEven[7:0]));
  wire presOdd = (regOdd == 3'h0) || (regOdd == 3'h2) ||
                 (regOdd == 3'h1 && ctrlPresent(absOdd[7:0]));

  // sources are never written, whatever the request says
  wire doWrite = reqValid & reqWrite & ~reqSource & ~undefinedAccess;
  wire doRead = reqValid & ~reqWrite & ~undefinedAccess;
  wire [7:0] byteEven = reqWord ? reqWdata[15:8] : reqWdata[7:0];
  wire [7:0] byteOdd = reqWdata[7:0];
  wire wrEven = doWrite & presEven;
  wire wrOdd = doWrite & reqWord & presOdd;
  wire ctlWrEven = wrEven & (regEven == 3'h1);
  wire ctlWrOdd = wrOdd & (regOdd == 3'h1);

  ////////////////////////////////////////////////////////////////////////
  // general-purpose storage
  wire [7:0] gpEven;
  wire [7:0] gpOdd;

  prf_gp_bank #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_bank (
    .clk(clk),
    .weEven(wrEven & (regEven == 3'h0)),
    .weOdd(wrOdd & (regOdd == 3'h0)),
    .addrEven(absEven[AW-1:0]),
    .addrOdd(absOdd[AW-1:0]),
    .wdataEven(byteEven),
    .wdataOdd(byteOdd),
    .rdataEven(gpEven),
    .rdataOdd(gpOdd)
  );

  function [7:0] readByte;
    input [2:0] r;
    input [7:0] a;
    input [7:0] gp;
    input pres;
    begin
      if (!pres) begin
        readByte = 8'h00;
      end else if (r == 3'h0) begin
        readByte = gp;
      end else if (r == 3'h1) begin
        readByte = ctrlRead(a);
      end else begin
        readByte = periphRdata;
      end
    end
  endfunction

  // control register write with software priority over hardware
  function [7:0] ctlNext;
    input [7:0] off;
    input [7:0] cur;
    input hwWe;
    input [7:0] hwVal;
    begin
      if (ctlWrEven && absEven[7:0] == off) begin
        ctlNext = byteEven;
      end else if (ctlWrOdd && absOdd[7:0] == off) begin
        ctlNext = byteOdd;
      end else if (hwWe) begin
        ctlNext = hwVal;
      end else begin
        ctlNext = cur;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pointer next value, written out in place: a function that reads
  // module state would hide those signals from the process sensitivity
  reg [7:0] next_ptr;

  always @* begin
    next_ptr = registerPointer;
    if (setPointer) begin
      next_ptr = setPointerData;
    end else if (ctlWrEven && absEven[7:0] == `PRF_OFF_REGISTER_POINTER) begin
      next_ptr = byteEven;
    end else if (ctlWrOdd && absOdd[7:0] == `PRF_OFF_REGISTER_POINTER) begin
      next_ptr = byteOdd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      registerPointer <= `PRF_RST_CTRL;
      conditionFlags <= `PRF_RST_CTRL;
      stackPointer <= {`PRF_RST_CTRL, `PRF_RST_CTRL};
      interruptMask1 <= `PRF_RST_CTRL;
      interruptRequest1 <= `PRF_RST_CTRL;
      interruptMask2 <= `PRF_RST_CTRL;
      interruptRequest2 <= `PRF_RST_CTRL;
    end else begin
      registerPointer <= next_ptr;
      conditionFlags <= ctlNext(`PRF_OFF_FLAGS, conditionFlags,
        hwFlagsWe, hwFlags);
      stackPointer[7:0] <= ctlNext(`PRF_OFF_SPL, stackPointer[7:0],
        hwSpWe, hwSp[7:0]);
      // absent optional registers stay at zero and so read as reserved
      stackPointer[15:8] <= (HAS_SPH != 0) ? ctlNext(`PRF_OFF_SPH,
        stackPointer[15:8], hwSpWe, hwSp[15:8]) : 8'h00;
      interruptMask1 <= ctlNext(`PRF_OFF_IMASK1, interruptMask1,
        1'b0, 8'h00);
      // hardware ORs request bits in; a software write that cycle wins
      interruptRequest1 <= ctlNext(`PRF_OFF_IREQ1, interruptRequest1,
        hwIrqSet1, interruptRequest1 | hwIrqBits1);
      interruptMask2 <= (HAS_IRQ2 != 0) ? ctlNext(`PRF_OFF_INTERRUPT_MASK_2,
        interruptMask2, 1'b0, 8'h00) : 8'h00;
      interruptRequest2 <= (HAS_IRQ2 != 0) ? ctlNext(`PRF_OFF_INTERRUPT_REQUEST_2,
        interruptRequest2, hwIrqSet2, interruptRequest2 | hwIrqBits2)
        : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer path: one cycle after the request. rdData holds until the
  // next read, so a consumer that looks late still finds it; the valid
  // and error flags are single-cycle pulses
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 16'h0000;
      rdValid <= 1'b0;
      accessError <= 1'b0;
    end else begin
      rdValid <= doRead;
      accessError <= reqValid & undefinedAccess;
      if (doRead) begin
        if (reqWord) begin
          rdData <= {readByte(regEven, absEven[7:0], gpEven, presEven),
                     readByte(regOdd, absOdd[7:0], gpOdd, presOdd)};
        end else begin
          rdData <= {8'h00,
                     readByte(regEven, absEven[7:0], gpEven, presEven)};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // peripheral strobes. the address leaves through a flop, so the
  // peripheral answers for the address of the previous cycle: a read
  // of C0-DF is right only when the same address was presented one
  // cycle ahead. kept so because every output comes from a flop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periphWe <= 1'b0;
      periphRe <= 1'b0;
      periphAddr <= 8'h00;
      periphWdata <= 8'h00;
    end else begin
      // peripherals take byte accesses; a word lands on its even byte
      periphWe <= wrEven & (regEven == 3'h2);
      periphRe <= doRead & (regEven == 3'h2);
      periphAddr <= absEven[7:0];
      // locked bits of a peripheral register are sent as zero in the write data
      periphWdata <= byteEven & ~writeLockMask;
    end
  end

endmodule

//--- rtl/prf_regs.vh
/*
 * constants of the paged register file: page 0 map, control offsets,
 * address modes and reset values.
 * assumes inclusion by bare name from rtl/ design files.
 */
`ifndef PRF_REGS_VH
`define PRF_REGS_VH

`define PRF_OFF_INTERRUPT_REQUEST_2 8'hF8
`define PRF_OFF_INTERRUPT_MASK_2 8'hF9
`define PRF_OFF_IREQ1 8'hFA
`define PRF_OFF_IMASK1 8'hFB
`define PRF_OFF_FLAGS 8'hFC
`define PRF_OFF_REGISTER_POINTER 8'hFD
`define PRF_OFF_SPH 8'hFE
`define PRF_OFF_SPL 8'hFF

`define PRF_NIB_CTRL 4'hF
`define PRF_NIB_VIRT 4'hE
`define PRF_NIB_PORT 4'hD
`define PRF_NIB_TIMER 4'hC

`define PRF_RST_CTRL 8'h00

`define PRF_MODE_IN_PAGE 2'h0
`define PRF_MODE_WORKING 2'h1
`define PRF_MODE_ABSOLUTE 2'h2

`define PRF_PAGE_ADDR_W 12

`endif

//--- tb/prf_periph_model.sv
/*
 * peripheral range model: stores bytes written to C0-DF.
 * assumes periphAddr/periphWdata are settled while periphWe is high.
 */
module prf_periph_model (
  input wire logic clk, // core clock
  input wire logic periphWe, // write strobe
  input wire logic [7:0] periphAddr, // in-page address
  input wire logic [7:0] periphWdata, // write data
  output logic [7:0] periphRdata // read data, combinational
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:31];
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge clk) begin
    if (periphWe) mem[periphAddr[4:0]] <= periphWdata;
  end
  assign periphRdata = mem[periphAddr[4:0]];
endmodule

//--- tb/prf_register_file_properties.sv
/*
 * port-level assertions of the paged register file.
 * assumes it is bound to prf_register_file, one clock domain.
 */
module prf_register_file_properties (
  input wire clk, // core clock
  input wire rst_n, // async reset, low
  input wire reqValid, // request strobe
  input wire reqWrite, // write flag
  input wire reqWord, // pair access
  input wire reqSource, // source operand
  input wire reqIndirect, // indirect address
  input wire [1:0] reqMode, // address mode
  input wire [11:0] reqAddr, // address
  input wire setPointer, // pointer load
  input wire [7:0] setPointerData, // pointer value
  input wire hwIrqSet1, // hw request set
  input wire [7:0] hwIrqBits1, // hw request bits
  input wire [7:0] writeLockMask, // locked bits
  input wire [15:0] rdData, // read data
  input wire rdValid, // read valid
  input wire accessError, // undefined access
  input wire periphWe, // periph write
  input wire [7:0] periphAddr, // periph address
  input wire [7:0] periphWdata, // periph data
  input wire [7:0] registerPointer, // pointer
  input wire [7:0] interruptRequest1 // requests 1
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_READ_CAUSE: assert property (rdValid |-> $past(reqValid) && !$past(reqWrite))
    else $error("read answer without read request");
  AST_ERR_EXCL: assert property (!(rdValid && accessError))
    else $error("answer and error together");
  AST_SRC_NOWR: assert property (reqValid && reqWrite && reqSource |=> !periphWe)
    else $error("source operand written");
  AST_PERIPH_RANGE: assert property (periphWe |-> periphAddr[7:5] == 3'h6)
    else $error("periph strobe outside C0-DF");
  AST_LOCK: assert property (periphWe |-> (periphWdata & $past(writeLockMask)) == 8'h00)
    else $error("locked bit written");
  AST_BYTE_UPPER: assert property (rdValid && !$past(reqWord) |-> rdData[15:8] == 8'h00)
    else $error("byte read upper not zero");
  AST_SETPTR: assert property (setPointer |=> registerPointer == $past(setPointerData))
    else $error("pointer load missed");
  AST_WIN_IND: assert property (reqValid && reqIndirect && reqMode == 2'h0 &&
    reqAddr[7:4] == 4'hE && registerPointer[3:0] == 4'h0 |=> accessError && !rdValid)
    else $error("indirect window not refused");
  AST_IRQ_SET: assert property (hwIrqSet1 && !reqValid |=>
    (interruptRequest1 & $past(hwIrqBits1)) == $past(hwIrqBits1))
    else $error("request bits not set");
endmodule
bind prf_register_file prf_register_file_properties prf_register_file_properties_inst (
  .clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqWrite(reqWrite),
  .reqWord(reqWord), .reqSource(reqSource), .reqIndirect(reqIndirect),
  .reqMode(reqMode), .reqAddr(reqAddr), .setPointer(setPointer),
  .setPointerData(setPointerData), .hwIrqSet1(hwIrqSet1),
  .hwIrqBits1(hwIrqBits1), .writeLockMask(writeLockMask), .rdData(rdData),
  .rdValid(rdValid), .accessError(accessError), .periphWe(periphWe),
  .periphAddr(periphAddr), .periphWdata(periphWdata),
  .registerPointer(registerPointer), .interruptRequest1(interruptRequest1));

//--- tb/tb.sv
/*
 * self-checking bench of prf_register_file with PAGES=2.
 * assumes a peripheral model answers the C0-DF range.
 */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic wd; logic [1:0] m; logic [11:0] a; logic [15:0] d, e;} prf_row_t;
  logic clk, rst_n, reqValid, reqWrite, reqWord, reqSource, reqIndirect;
  logic setPointer, hwFlagsWe, hwIrqSet1, hwIrqSet2, hwSpWe, rdValid;
  logic accessError, periphWe, periphRe;
  logic [1:0] reqMode;
  logic [11:0] reqAddr;
  logic [15:0] reqWdata, hwSp, rdData, stackPointer;
  logic [7:0] setPointerData, hwFlags, hwIrqBits1, hwIrqBits2, writeLockMask;
  logic [7:0] periphRdata, periphAddr, periphWdata, registerPointer;
  logic [7:0] conditionFlags, interruptMask1, interruptRequest1;
  logic [7:0] interruptMask2, interruptRequest2;
  logic gotValid, gotErr, gotRe;
  logic [15:0] gotData;
  int failures, cmp_count, cycles;
  // page 2 is not built with PAGES=2, so it reads zero
  prf_row_t rows [10] = '{'{0,0,12'h010,16'h005A,16'h005A},
    '{0,0,12'h0F5,16'h0033,16'h0000}, '{0,0,12'h090,16'h0044,16'h0000},
    '{0,0,12'h0FC,16'h003C,16'h003C}, '{0,0,12'h0FE,16'h0012,16'h0012},
    '{0,0,12'h0F9,16'h0066,16'h0066}, '{1,0,12'h020,16'hA1B2,16'hA1B2},
    '{0,2,12'h133,16'h0077,16'h0077}, '{0,2,12'h233,16'h0088,16'h0000},
    '{0,0,12'h0FB,16'h0011,16'h0011}};
  prf_register_file #(.PAGES(2)) prf_register_file_inst (.clk(clk),
    .rst_n(rst_n), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqWord(reqWord), .reqSource(reqSource), .reqIndirect(reqIndirect),
    .reqMode(reqMode), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .setPointer(setPointer), .setPointerData(setPointerData),
    .hwFlagsWe(hwFlagsWe), .hwFlags(hwFlags), .hwIrqSet1(hwIrqSet1),
    .hwIrqBits1(hwIrqBits1), .hwIrqSet2(hwIrqSet2), .hwIrqBits2(hwIrqBits2),
    .hwSpWe(hwSpWe), .hwSp(hwSp), .writeLockMask(writeLockMask),
    .periphRdata(periphRdata), .rdData(rdData), .rdValid(rdValid),
    .accessError(accessError), .periphWe(periphWe), .periphRe(periphRe),
    .periphAddr(periphAddr), .periphWdata(periphWdata),
    .registerPointer(registerPointer), .conditionFlags(conditionFlags),
    .stackPointer(stackPointer), .interruptMask1(interruptMask1),
    .interruptRequest1(interruptRequest1), .interruptMask2(interruptMask2),
    .interruptRequest2(interruptRequest2));
  prf_periph_model prf_periph_model_inst (.clk(clk), .periphWe(periphWe),
    .periphAddr(periphAddr), .periphWdata(periphWdata),
    .periphRdata(periphRdata));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one request, then one idle cycle; the answer pulses are caught mid-way
  task automatic acc(input logic w, wd, src, ind, input logic [1:0] m,
    input logic [11:0] a, input logic [15:0] d);
    reqValid = 1'b1;
    reqWrite = w;
    reqWord = wd;
    reqSource = src;
    reqIndirect = ind;
    reqMode = m;
    reqAddr = a;
    reqWdata = d;
    @(negedge clk);
    gotValid = rdValid;
    gotErr = accessError;
    gotRe = periphRe;
    gotData = rdData;
    reqValid = 1'b0;
    @(negedge clk);
  endtask
  task automatic setp(input logic [7:0] v);
    setPointer = 1'b1;
    setPointerData = v;
    @(negedge clk);
    setPointer = 1'b0;
    check({8'h00, registerPointer}, {8'h00, v});
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end
  initial begin
    {rst_n, reqValid, reqWrite, reqWord, reqSource, reqIndirect} = '0;
    {setPointer, hwFlagsWe, hwIrqSet1, hwIrqSet2, hwSpWe} = '0;
    {reqMode, reqAddr, reqWdata, hwSp, setPointerData, hwFlags} = '0;
    {hwIrqBits1, hwIrqBits2, writeLockMask} = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    check({registerPointer, conditionFlags}, 16'h0000);
    foreach (rows[i]) begin
      acc(1, rows[i].wd, 0, 0, rows[i].m, rows[i].a, rows[i].d);
      acc(0, rows[i].wd, 0, 0, rows[i].m, rows[i].a, 16'h0000);
      check({15'h0000, gotValid}, 16'h0001);
      check(gotData, rows[i].e);
    end
    check(stackPointer, 16'h1200);
    check({interruptMask1, interruptMask2}, 16'h1166);
    acc(0, 0, 0, 0, 0, 12'h021, 16'h0000);
    check(rdData, 16'h00B2);
    acc(1, 0, 1, 0, 0, 12'h010, 16'h00FF);
    acc(0, 0, 0, 0, 0, 12'h010, 16'h0000);
    check(rdData, 16'h005A);
    setp(8'h10);
    acc(1, 0, 0, 0, 1, 12'h003, 16'h0099);
    acc(0, 0, 0, 0, 0, 12'h013, 16'h0000);
    check(rdData, 16'h0099);
    acc(0, 0, 0, 0, 0, 12'h0E3, 16'h0000);
    check(rdData, 16'h0099);
    reqIndirect = 1'b1;
    @(negedge clk);
    check({15'h0000, accessError}, 16'h0000);
    acc(0, 0, 0, 1, 0, 12'h0E3, 16'h0000);
    check({14'h0000, gotErr, gotValid}, 16'h0002);
    setp(8'h11);
    acc(0, 0, 0, 0, 0, 12'h033, 16'h0000);
    check(rdData, 16'h0077);
    setp(8'h00);
    // software write and hardware load of the flags in one cycle
    {hwFlagsWe, hwFlags, reqValid, reqWrite} = {1'b1, 8'hAA, 1'b1, 1'b1};
    {reqAddr, reqWdata} = {12'h0FC, 16'h0055};
    @(negedge clk);
    reqValid = 1'b0;
    check({8'h00, conditionFlags}, 16'h0055);
    @(negedge clk);
    hwFlagsWe = 1'b0;
    check({8'h00, conditionFlags}, 16'h00AA);
    hwIrqSet1 = 1'b1;
    hwIrqBits1 = 8'h05;
    @(negedge clk);
    check({8'h00, interruptRequest1}, 16'h0005);
    {reqValid, reqAddr, reqWdata} = {1'b1, 12'h0FA, 16'h0030};
    @(negedge clk);
    {reqValid, hwIrqSet1} = '0;
    check({8'h00, interruptRequest1}, 16'h0030);
    {hwSpWe, hwSp, hwIrqSet2, hwIrqBits2} = {1'b1, 16'h3456, 1'b1, 8'h81};
    @(negedge clk);
    {hwSpWe, hwIrqSet2} = '0;
    check(stackPointer, 16'h3456);
    check({8'h00, interruptRequest2}, 16'h0081);
    writeLockMask = 8'h0F;
    acc(1, 0, 0, 0, 0, 12'h0D2, 16'h00AB);
    writeLockMask = 8'h00;
    check({8'h00, prf_periph_model_inst.mem[18]}, 16'h00A0);
    acc(0, 0, 0, 0, 0, 12'h0D2, 16'h0000);
    check(gotData, 16'h00A0);
    check({15'h0000, gotRe}, 16'h0001);
    acc(1, 0, 1, 0, 0, 12'h0D2, 16'h00FF);
    check({8'h00, prf_periph_model_inst.mem[18]}, 16'h00A0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check({registerPointer, conditionFlags}, 16'h0000);
    acc(0, 0, 0, 0, 0, 12'h010, 16'h0000);
    check(rdData, 16'h005A);
    results();
  end
endmodule
